// >>> core/pvrs_sequencer.sv
// Rail enable sequencer with Avalon-MM settings port
//
// Our own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps
`include "pvrs_params.svh"

module pvrs_sequencer
  import pvrs_pkg::*;
#(
  parameter int unsigned PG_LOSS_CYCLES = `PVRS_PG_LOSS_CYC
)
(
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             resetn,
  // Avalon-MM slave
  input  wire logic [5:0]       address,
  input  wire logic             read,
  input  wire logic             write,
  input  wire logic [31:0]      writedata,
  output logic [31:0]           readdata,
  output logic                  waitrequest,
  // Control pins
  input  wire logic             primary_sequence_input,
  input  wire logic             secondary_sequence_input,
  input  wire logic             ddr_term_enable_input,
  input  wire logic             switch_ab_enable_input,
  input  wire logic             switch_b2_enable_input,
  input  wire logic             sleep_select_input,
  // Regulator feedback pins
  input  wire logic [5:0]       buck_pg_in,
  input  wire logic [12:0]      fault_in,
  // Regulator enables and settings
  output logic [5:0]            buck_enable,
  output logic [5:0][6:0]       buck_vid,
  output logic [5:0]            buck_force_pwm,
  output logic                  general_linear_reg_one_en,
  output logic                  general_linear_reg_two_en,
  output logic                  general_linear_reg_three_en,
  output logic                  load_switch_a_en,
  output logic                  load_switch_b_one_en,
  output logic                  load_switch_b_two_en,
  output logic                  ddr_termination_regulator_en,
  // Open-drain outputs, level is always low
  output logic                  pg_output_one_out,
  output logic                  pg_output_one_oe,
  output logic                  system_pg_output_out,
  output logic                  system_pg_output_oe,
  output logic                  host_output_three_out,
  output logic                  host_output_three_oe,
  output logic                  host_output_four_out,
  output logic                  host_output_four_oe,
  // Interrupt
  output logic                  irq
);

  localparam logic [17:0] LOSS_LAST = 18'(PG_LOSS_CYCLES - 1);
  localparam logic [5:0]  FINE_STEP = `PVRS_FINE_STEP_MASK;
  localparam logic [5:0]  SLEEP_EN  = `PVRS_SLEEP_EN_MASK;

  pvrs_state_s state_reg;
  pvrs_state_s state_next;

  logic [24:0] raw_in;
  logic [5:0]  ctl;
  logic [5:0]  pg;
  logic [12:0] fault;
  logic [5:0]  src_on;
  logic [5:0]  up_pg;
  logic        req;
  logic        do_wr;
  logic [2:0]  buck_idx;
  logic        buck_hit;
  logic [12:0] clr;

  assign raw_in = {fault_in, buck_pg_in, sleep_select_input, switch_b2_enable_input,
                   switch_ab_enable_input, ddr_term_enable_input,
                   secondary_sequence_input, primary_sequence_input};
  assign ctl   = state_reg.filt[5:0];
  assign pg    = state_reg.filt[11:6];
  assign fault = state_reg.filt[24:12];
  assign req   = read | write;
  assign do_wr = write & state_reg.ack;
  assign buck_hit = (address >= `PVRS_OFS_BUCK_BASE) && (address <= `PVRS_OFS_BUCK_LAST);
  assign buck_idx = 3'((address - `PVRS_OFS_BUCK_BASE) >> 2);

  always_comb
  begin
    state_next = state_reg;
    clr = '0;

    // Three-stage synchroniser; a change counts when stages two and three agree
    state_next.s1 = raw_in;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    state_next.filt = (state_reg.s2 & ~(state_reg.s2 ^ state_reg.s3))
                    | (state_reg.filt & (state_reg.s2 ^ state_reg.s3));

    // Rail one on the primary input, the rest chained on the secondary input
    src_on = {{5{ctl[1]}}, ctl[0]};
    up_pg  = {pg[4:0], 1'b1};

    for (int i = 0; i < 6; i++)
    begin
      if (src_on[i] && up_pg[i])
      begin
        state_next.buck_en[i] = 1'b1;
        state_next.tmr[i] = '0;
      end
      else if (!src_on[i])
      begin
        state_next.buck_en[i] = 1'b0;
        state_next.tmr[i] = '0;
      end
      else if (state_reg.buck_en[i])
      begin
        if (state_reg.tmr[i] == LOSS_LAST)
        begin
          state_next.buck_en[i] = 1'b0;
          state_next.tmr[i] = '0;
        end
        else
        begin
          state_next.tmr[i] = state_reg.tmr[i] + 18'h00001;
        end
      end
      else
      begin
        state_next.tmr[i] = '0;
      end
      state_next.pwm_out[i] = state_reg.cfg[i].force_pwm;
      if (SLEEP_EN[i] && ctl[5])
      begin
        state_next.vid_out[i] = state_reg.cfg[i].sleep_vid;
      end
      else
      begin
        state_next.vid_out[i] = state_reg.cfg[i].vid;
      end
    end

    // Loads on pins and on software
    state_next.vtt_en = ctl[2];
    state_next.sw_en[0] = ctl[3];
    state_next.sw_en[1] = ctl[3];
    state_next.sw_en[2] = ctl[4] & state_reg.sw_lin;
    state_next.ldo_en[0] = state_reg.lin_sw;
    state_next.ldo_en[1] = state_reg.ldo_sw[0];
    state_next.ldo_en[2] = state_reg.ldo_sw[1];

    // Open-drain outputs: enable high pulls the pin low
    state_next.gpo_oe[0] = !(ctl[0] && pg[0]);
    state_next.gpo_oe[1] = !(ctl[0] && ctl[1] && (&pg));
    state_next.gpo_oe[2] = !state_reg.host_lvl[0];
    state_next.gpo_oe[3] = !state_reg.host_lvl[1];

    // Bus: one wait cycle, then the access completes
    state_next.ack = req & !state_reg.ack;
    if (req && !state_reg.ack)
    begin
      state_next.rdata = '0;
      if (read)
      begin
        if (buck_hit)
        begin
          state_next.rdata = {16'h0000, FINE_STEP[buck_idx], state_reg.cfg[buck_idx]};
        end
        else
        begin
          unique case (address)
            `PVRS_OFS_LIN_SW:     state_next.rdata = {31'h0, state_reg.lin_sw};
            `PVRS_OFS_SW_LIN:     state_next.rdata = {31'h0, state_reg.sw_lin};
            `PVRS_OFS_LDO_CTRL:   state_next.rdata = {30'h0, state_reg.ldo_sw};
            `PVRS_OFS_HOST_OUT:   state_next.rdata = {30'h0, state_reg.host_lvl};
            `PVRS_OFS_INT_STATUS: state_next.rdata = {19'h0, state_reg.status};
            `PVRS_OFS_INT_MASK:   state_next.rdata = {19'h0, state_reg.mask};
            `PVRS_OFS_FAULT_MASK: state_next.rdata = {19'h0, `PVRS_FAULT_MASK_RST};
            `PVRS_OFS_RAIL_STATE: state_next.rdata = {14'h0, state_reg.vtt_en,
                                                      state_reg.sw_en, state_reg.ldo_en,
                                                      state_reg.gpo_oe, state_reg.buck_en};
            default:              state_next.rdata = '0;
          endcase
        end
      end
    end

    if (do_wr)
    begin
      if (buck_hit)
      begin
        state_next.cfg[buck_idx] = writedata[14:0];
      end
      else
      begin
        unique case (address)
          `PVRS_OFS_LIN_SW:     state_next.lin_sw = writedata[0];
          `PVRS_OFS_SW_LIN:     state_next.sw_lin = writedata[0];
          `PVRS_OFS_LDO_CTRL:   state_next.ldo_sw = writedata[1:0];
          `PVRS_OFS_HOST_OUT:   state_next.host_lvl = writedata[1:0];
          `PVRS_OFS_INT_STATUS: clr = writedata[12:0];
          `PVRS_OFS_INT_MASK:   state_next.mask = writedata[12:0];
          default:              ;
        endcase
      end
    end

    // Sticky fault flags; a new fault beats a clear in the same cycle
    state_next.status = (state_reg.status & ~clr)
                      | (fault & ~`PVRS_FAULT_MASK_RST);
    state_next.irq = |(state_reg.status & state_reg.mask);
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= '0;
      state_reg.gpo_oe <= 4'hf;
      state_reg.sw_lin <= `PVRS_SW_LIN_RST;
      state_reg.cfg[0] <= {`PVRS_STEP_DOWN_RAIL_ONE_VID, 1'b0, `PVRS_STEP_DOWN_RAIL_ONE_VID};
      state_reg.cfg[1] <= {`PVRS_BUCK2_VID, 1'b0, `PVRS_BUCK2_VID};
      state_reg.cfg[2] <= {`PVRS_BUCK3_VID, 1'b0, `PVRS_BUCK3_VID};
      state_reg.cfg[3] <= {`PVRS_BUCK4_VID, 1'b0, `PVRS_BUCK4_VID};
      state_reg.cfg[4] <= {`PVRS_BUCK5_VID, 1'b0, `PVRS_BUCK5_VID};
      state_reg.cfg[5] <= {`PVRS_STEP_DOWN_RAIL_SIX_SLP_VID, 1'b0, `PVRS_STEP_DOWN_RAIL_SIX_VID};
      state_reg.vid_out[0] <= `PVRS_STEP_DOWN_RAIL_ONE_VID;
      state_reg.vid_out[1] <= `PVRS_BUCK2_VID;
      state_reg.vid_out[2] <= `PVRS_BUCK3_VID;
      state_reg.vid_out[3] <= `PVRS_BUCK4_VID;
      state_reg.vid_out[4] <= `PVRS_BUCK5_VID;
      state_reg.vid_out[5] <= `PVRS_STEP_DOWN_RAIL_SIX_VID;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register; open-drain output levels tied low
  assign readdata                     = state_reg.rdata;
  assign waitrequest                  = !state_reg.ack;
  assign buck_enable                  = state_reg.buck_en;
  assign buck_vid                     = state_reg.vid_out;
  assign buck_force_pwm               = state_reg.pwm_out;
  assign general_linear_reg_one_en    = state_reg.ldo_en[0];
  assign general_linear_reg_two_en    = state_reg.ldo_en[1];
  assign general_linear_reg_three_en  = state_reg.ldo_en[2];
  assign load_switch_a_en             = state_reg.sw_en[0];
  assign load_switch_b_one_en         = state_reg.sw_en[1];
  assign load_switch_b_two_en         = state_reg.sw_en[2];
  assign ddr_termination_regulator_en = state_reg.vtt_en;
  assign pg_output_one_out            = 1'b0;
  assign pg_output_one_oe             = state_reg.gpo_oe[0];
  assign system_pg_output_out         = 1'b0;
  assign system_pg_output_oe          = state_reg.gpo_oe[1];
  assign host_output_three_out        = 1'b0;
  assign host_output_three_oe         = state_reg.gpo_oe[2];
  assign host_output_four_out         = 1'b0;
  assign host_output_four_oe          = state_reg.gpo_oe[3];
  assign irq                          = state_reg.irq;

endmodule

// >>> core/pvrs_params.svh
// Offsets, field positions, reset values and timing counts of the rail sequencer
// Function
// - Enables follow control input plus upstream power-good
// - Both inputs low: both chains stop together
// - Primary first: power-good outputs low, chain unwinds
// - Lost upstream power-good waits 4 ms first
// - Switch A and B one follow input
// - Switch B two follows its input
// - Linear regs two, three by software only
// - Shared sets drive linear one, switch B two
// - Rail one 1 V fine steps, others coarse
// - Only rail six sleeps: 1.5/1.35 V
// - Termination regulator on input, faults unmasked
// - Linear and switch faults masked, rails unmasked
// - Host outputs default low, power-good outputs open-drain
`ifndef PVRS_PARAMS_SVH
`define PVRS_PARAMS_SVH

`define PVRS_CLK_HZ          40000000
`define PVRS_PG_LOSS_MS      4
`define PVRS_PG_LOSS_CYC     ((`PVRS_PG_LOSS_MS * `PVRS_CLK_HZ) / 1000)

`define PVRS_OFS_LIN_SW      6'h00
`define PVRS_OFS_SW_LIN      6'h04
`define PVRS_OFS_LDO_CTRL    6'h08
`define PVRS_OFS_HOST_OUT    6'h0c
`define PVRS_OFS_INT_STATUS  6'h10
`define PVRS_OFS_INT_MASK    6'h14
`define PVRS_OFS_FAULT_MASK  6'h18
`define PVRS_OFS_RAIL_STATE  6'h1c
`define PVRS_OFS_BUCK_BASE   6'h20
`define PVRS_OFS_BUCK_LAST   6'h34

`define PVRS_STEP_DOWN_RAIL_ONE_VID       7'h3c
`define PVRS_BUCK2_VID       7'h38
`define PVRS_BUCK3_VID       7'h20
`define PVRS_BUCK4_VID       7'h54
`define PVRS_BUCK5_VID       7'h74
`define PVRS_STEP_DOWN_RAIL_SIX_VID       7'h2c
`define PVRS_STEP_DOWN_RAIL_SIX_SLP_VID   7'h26
`define PVRS_FINE_STEP_MASK  6'h01
`define PVRS_SLEEP_EN_MASK   6'h20
`define PVRS_FAULT_MASK_RST  13'h1f80
`define PVRS_SW_LIN_RST      1'h1

`endif

// >>> core/pvrs_pkg.sv
// Types shared by the rail sequencer
package pvrs_pkg;

  typedef struct packed {
    logic [6:0] sleep_vid;
    logic       force_pwm;
    logic [6:0] vid;
  } pvrs_buck_cfg_s;

  typedef struct packed {
    logic [24:0]             s1;
    logic [24:0]             s2;
    logic [24:0]             s3;
    logic [24:0]             filt;
    logic [5:0]              buck_en;
    logic [5:0][17:0]        tmr;
    logic [5:0][6:0]         vid_out;
    logic [5:0]              pwm_out;
    logic [2:0]              ldo_en;
    logic [2:0]              sw_en;
    logic                    vtt_en;
    logic [3:0]              gpo_oe;
    logic                    lin_sw;
    logic                    sw_lin;
    logic [1:0]              ldo_sw;
    logic [1:0]              host_lvl;
    logic [12:0]             status;
    logic [12:0]             mask;
    logic [5:0]              buck_cfg_dummy;
    pvrs_buck_cfg_s [5:0]    cfg;
    logic                    ack;
    logic [31:0]             rdata;
    logic                    irq;
  } pvrs_state_s;

endpackage

// >>> tb/pvrs_assertions.sv
// Port checker for the rail sequencer
`timescale 1ns/100ps
`include "pvrs_params.svh"
module pvrs_assertions
  import pvrs_pkg::*;
(
  // Clock, reset and bus
  input wire logic            clock,
  input wire logic            resetn,
  input wire logic            read,
  input wire logic            write,
  input wire logic            waitrequest,
  // Control pins
  input wire logic            primary_sequence_input,
  input wire logic            ddr_term_enable_input,
  input wire logic            switch_ab_enable_input,
  input wire logic            sleep_select_input,
  // Outputs
  input wire logic [5:0]      buck_enable,
  input wire logic [5:0][6:0] buck_vid,
  input wire logic            general_linear_reg_two_en,
  input wire logic            load_switch_a_en,
  input wire logic            load_switch_b_one_en,
  input wire logic            ddr_termination_regulator_en,
  input wire logic            pg_output_one_oe,
  input wire logic            system_pg_output_oe,
  input wire logic            host_output_three_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_prim_low;
    !primary_sequence_input [*7];
  endsequence
  chk_wait_answer: assert property ($rose(read) || $rose(write) |=> !waitrequest)
    else $error("bus not answered");
  chk_wait_single: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low too long");
  chk_rail_one_off: assert property (s_prim_low |-> !buck_enable[0])
    else $error("rail one on without input");
  chk_pg_drop: assert property (s_prim_low |-> pg_output_one_oe && system_pg_output_oe)
    else $error("power-good outputs not low");
  chk_switch_pair: assert property (load_switch_a_en == load_switch_b_one_en)
    else $error("switch a and b one differ");
  chk_switch_follow: assert property (switch_ab_enable_input [*7] |-> load_switch_a_en)
    else $error("switch a not on");
  chk_vtt_follow: assert property ($stable(ddr_term_enable_input) [*7]
    |-> ddr_termination_regulator_en == ddr_term_enable_input)
    else $error("termination enable wrong");
  chk_sleep_vid: assert property ($stable(sleep_select_input) [*7] |-> buck_vid[5] ==
    (sleep_select_input ? `PVRS_STEP_DOWN_RAIL_SIX_SLP_VID : `PVRS_STEP_DOWN_RAIL_SIX_VID))
    else $error("rail six code wrong");
  chk_lin_sw_only: assert property ($changed(general_linear_reg_two_en)
    |-> $past(write) || $past(write, 2) || $past(write, 3))
    else $error("linear two moved without write");
  chk_host_low: assert property (!host_output_three_out)
    else $error("host output drives high");
endmodule

bind pvrs_sequencer pvrs_assertions pvrs_assertions_i (.clock, .resetn, .read, .write,
  .waitrequest, .primary_sequence_input, .ddr_term_enable_input, .switch_ab_enable_input,
  .sleep_select_input, .buck_enable, .buck_vid, .general_linear_reg_two_en, .load_switch_a_en,
  .load_switch_b_one_en, .ddr_termination_regulator_en, .pg_output_one_oe,
  .system_pg_output_oe, .host_output_three_out);

// >>> tb/pvrs_rail_model.sv
// Regulator model returning power-good for enabled rails
`timescale 1ns/100ps
module pvrs_rail_model
(
  // Clock and reset
  input wire logic        clock,
  input wire logic        resetn,
  // Enables and injected power-good losses
  input wire logic [5:0]  buck_enable,
  input wire logic [5:0]  kill,
  // Power-good back to the sequencer
  output logic [5:0]      buck_pg_in
);
  always_ff @(posedge clock or negedge resetn)
    if (!resetn)
      buck_pg_in <= 6'h00;
    else
      buck_pg_in <= buck_enable & ~kill;
endmodule

// >>> tb/tb.sv
// Self-checking bench for the rail sequencer
`timescale 1ns/100ps
`include "pvrs_params.svh"
module tb
  import pvrs_pkg::*;
;
  logic clock, resetn, read, write, waitrequest, irq, primary_sequence_input;
  logic secondary_sequence_input, ddr_term_enable_input, switch_ab_enable_input;
  logic switch_b2_enable_input, sleep_select_input, pg_output_one_oe, system_pg_output_oe;
  logic general_linear_reg_one_en, general_linear_reg_two_en, general_linear_reg_three_en;
  logic load_switch_a_en, load_switch_b_one_en, load_switch_b_two_en;
  logic ddr_termination_regulator_en, host_output_three_oe, host_output_four_oe;
  logic [5:0]      address, buck_pg_in, buck_enable, kill;
  logic [31:0]     writedata, readdata, q, seed;
  logic [12:0]     fault_in;
  logic [5:0][6:0] buck_vid;
  int              error_cnt, checked, n;

  pvrs_sequencer #(.PG_LOSS_CYCLES(20)) pvrs_sequencer_i (.clock, .resetn, .address, .read,
    .write, .writedata, .readdata, .waitrequest, .primary_sequence_input,
    .secondary_sequence_input, .ddr_term_enable_input, .switch_ab_enable_input,
    .switch_b2_enable_input, .sleep_select_input, .buck_pg_in, .fault_in, .buck_enable,
    .buck_vid, .buck_force_pwm(), .general_linear_reg_one_en, .general_linear_reg_two_en,
    .general_linear_reg_three_en, .load_switch_a_en, .load_switch_b_one_en,
    .load_switch_b_two_en, .ddr_termination_regulator_en, .pg_output_one_out(),
    .pg_output_one_oe, .system_pg_output_out(), .system_pg_output_oe,
    .host_output_three_out(), .host_output_three_oe, .host_output_four_out(),
    .host_output_four_oe, .irq);
  pvrs_rail_model pvrs_rail_model_i (.clock, .resetn, .buck_enable, .kill, .buck_pg_in);

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [31:0] exp_cfg(input int i);
    logic [6:0] v [6];
    v = '{`PVRS_STEP_DOWN_RAIL_ONE_VID, `PVRS_BUCK2_VID, `PVRS_BUCK3_VID, `PVRS_BUCK4_VID,
      `PVRS_BUCK5_VID, `PVRS_STEP_DOWN_RAIL_SIX_VID};
    return {16'h0, i == 0, i == 5 ? `PVRS_STEP_DOWN_RAIL_SIX_SLP_VID : v[i], 1'b0, v[i]};
  endfunction

  task print_verdict;
    if (error_cnt == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task bus(input logic [5:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge clock);
    address <= a;
    write <= w;
    read <= !w;
    writedata <= d;
    k = 0;
    do
    begin
      @(posedge clock);
      k++;
    end
    while (waitrequest !== 1'b0 && k < 50);
    q = readdata;
    if (k == 50)
    begin
      cmp("bus_timeout", 0, 1);
      print_verdict();
    end
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask
  task wait_rails(input logic [5:0] v);
    n = 0;
    while (buck_enable !== v && n < 400)
    begin
      @(posedge clock);
      n++;
    end
    if (n == 400)
    begin
      cmp("rail_timeout", v, buck_enable);
      print_verdict();
    end
  endtask
  task up;
    primary_sequence_input <= 1'b1;
    secondary_sequence_input <= 1'b1;
    wait_rails(6'h3f);
    repeat (8) @(posedge clock);
    cmp("pg_oe", 0, {pg_output_one_oe, system_pg_output_oe});
  endtask

  initial
  begin
    {read, write, primary_sequence_input, secondary_sequence_input} = 4'h0;
    {ddr_term_enable_input, switch_ab_enable_input, switch_b2_enable_input} = 3'h0;
    {sleep_select_input, address, writedata, fault_in, kill} = '0;
    {error_cnt, checked} = '0;
    seed = 32'd74572;
    resetn = 1'b0;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      bus(6'h20 + 6'(4 * i), 1'b0, 0);
      cmp("rail_cfg", exp_cfg(i), q);
    end
    bus(6'h18, 1'b0, 0);
    cmp("fault_mask", 32'h1f80, q);
    bus(6'h04, 1'b0, 0);
    cmp("b2_permit", 1, q);
    bus(6'h0c, 1'b0, 0);
    cmp("host_level", 0, {q[29:0], host_output_three_oe, host_output_four_oe} ^ 2'b11);
    bus(6'h3c, 1'b0, 0);
    cmp("unmapped", 0, q);
    for (int i = 0; i < 40; i++)
    begin
      seed = xs(seed);
      {sleep_select_input, ddr_term_enable_input} <= seed[3:2];
      {switch_b2_enable_input, switch_ab_enable_input} <= seed[1:0];
      repeat (8) @(posedge clock);
      cmp("sw_ab", {2{seed[0]}}, {load_switch_a_en, load_switch_b_one_en});
      cmp("sw_b2", seed[1], load_switch_b_two_en);
      cmp("vtt", seed[2], ddr_termination_regulator_en);
      cmp("vid6", seed[3] ? `PVRS_STEP_DOWN_RAIL_SIX_SLP_VID : `PVRS_STEP_DOWN_RAIL_SIX_VID, buck_vid[5]);
    end
    up();
    {primary_sequence_input, secondary_sequence_input} <= 2'b00;
    repeat (8) @(posedge clock);
    cmp("both_low", 0, buck_enable);
    up();
    primary_sequence_input <= 1'b0;
    repeat (7) @(posedge clock);
    cmp("prim_first", 3'b111, {pg_output_one_oe, system_pg_output_oe, buck_enable[1]});
    wait_rails(6'h00);
    cmp("unwind_slow", 1, n >= 90);
    up();
    kill <= 6'h02;
    wait_rails(6'h3b);
    cmp("loss_wait", 1, n >= 20 && n <= 30);
    kill <= 6'h00;
    wait_rails(6'h3f);
    switch_b2_enable_input <= 1'b1;
    bus(6'h08, 1'b1, 3);
    bus(6'h00, 1'b1, 1);
    bus(6'h04, 1'b1, 0);
    bus(6'h0c, 1'b1, 3);
    repeat (3) @(posedge clock);
    cmp("lin", 7, {general_linear_reg_one_en, general_linear_reg_two_en,
      general_linear_reg_three_en});
    cmp("b2_permit_off", 0, load_switch_b_two_en);
    cmp("host_rel", 0, {host_output_three_oe, host_output_four_oe});
    bus(6'h14, 1'b1, 32'h1fff);
    fault_in <= 13'h0081;
    repeat (8) @(posedge clock);
    fault_in <= 13'h0000;
    bus(6'h10, 1'b0, 0);
    repeat (3) @(posedge clock);
    cmp("status", 1, q);
    cmp("irq_set", 1, irq);
    bus(6'h10, 1'b1, 1);
    repeat (3) @(posedge clock);
    cmp("irq_clr", 0, irq);
    bus(6'h14, 1'b1, 0);
    fault_in <= 13'h0040;
    repeat (8) @(posedge clock);
    fault_in <= 13'h0000;
    cmp("irq_masked", 0, irq);
    bus(6'h14, 1'b1, 32'h0040);
    repeat (3) @(posedge clock);
    cmp("irq_unmask", 1, irq);
    print_verdict();
  end
endmodule
